// ---- ccd_pkg.sv ----
package ccd_pkg;
  // command byte layout
  localparam int CMD_MSB  = 7;
  localparam int CMD_LSB  = 5;
  localparam int DAT_MSB  = 4;
  localparam int RST_BIT  = 4;
  localparam int CLK_MSB  = 3;
  localparam int CLK_LSB  = 2;
  localparam int VCC_MSB  = 1;
  localparam int VCC_LSB  = 0;
  localparam int SYN_CLK  = 3;
  localparam int SYN_IO   = 2;
  localparam int SYN_AUXA = 1;
  localparam int SYN_AUXB = 0;
  localparam int BYTE_W   = 8;
  localparam int CNT_W    = 4;

  // command codes
  localparam logic [2:0] CMD_EXT_ASYNC = 3'h4;
  localparam logic [2:0] CMD_CONFIG    = 3'h5;
  localparam logic [2:0] CMD_EXT_SYNC  = 3'h6;
  localparam logic [2:0] CMD_RESERVED  = 3'h7;

  // configuration data values
  localparam logic [4:0] CFG_DET_OPEN   = 5'h00;
  localparam logic [4:0] CFG_DET_CLOSED = 5'h01;
  localparam logic [4:0] CFG_EDGE_SPEC  = 5'h02;
  localparam logic [4:0] CFG_EDGE_NORM  = 5'h03;
  localparam logic [4:0] CFG_SLOPE_SLOW = 5'h04;
  localparam logic [4:0] CFG_SLOPE_FAST = 5'h05;

  // supply codes: off, 1.8 V, 3.0 V, 5.0 V
  localparam logic [1:0] VCC_OFF = 2'h0;
  // card clock select: low, /1, /2, /4 of the card time base
  localparam logic [1:0] CKS_LOW  = 2'h0;
  localparam logic [1:0] CKS_DIV1 = 2'h1;
  localparam logic [1:0] CKS_DIV2 = 2'h2;
  localparam logic [1:0] CKS_DIV4 = 2'h3;

  // reset values
  localparam logic RST_DET_POL = 1'b0;
  localparam logic RST_SPECIAL = 1'b0;
  localparam logic RST_FAST    = 1'b0;

  // host timing, in clock_i cycles
  localparam int HALF_CYC  = 4;
  localparam int SETUP_CYC = 4;
  localparam int GAP_CYC   = 8;
  localparam int TICK_W    = 4;
endpackage : ccd_pkg

// ---- ccd_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ccd_link_if;
  logic link_clk;
  logic cs_n;
  logic mosi;
  logic miso;

  modport host (output link_clk, output cs_n, output mosi, input miso);
  modport device (input link_clk, input cs_n, input mosi, output miso);
endinterface : ccd_link_if
`default_nettype wire

// ---- ccd_coupler.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_coupler (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  ccd_link_if.device                  link,
  input  wire logic                   slot_address_pin_low_i,
  input  wire logic                   slot_address_pin_high_i,
  input  wire logic                   card_data_line_i,
  output logic [1:0]                  card_supply_output_o,
  output logic                        card_clock_output_o,
  output logic                        card_clock_fast_slope_o,
  output logic                        card_reset_output_o,
  output logic                        card_data_line_o,
  output logic                        card_data_line_oe_n_o,
  output logic                        card_aux_contact_a_o,
  output logic                        card_aux_contact_a_oe_n_o,
  output logic                        card_aux_contact_b_o,
  output logic                        card_aux_contact_b_oe_n_o,
  output logic                        card_detect_polarity_o,
  output logic                        serial_edge_special_o
);
  import ccd_pkg::*;

  logic [CNT_W-1:0]  bit_cnt_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [BYTE_W-1:0] rb_ff;
  logic              rise_ff;
  logic              fall_ff;
  logic [2:0]        done_sync_ff;
  logic [1:0]        cs_sync_ff;
  logic [1:0]        slot_s1_ff;
  logic [1:0]        slot_s2_ff;
  logic [1:0]        io_sync_ff;
  logic [2:0]        cmd;
  logic [4:0]        dat;
  logic              take;
  logic              prog;
  logic              sync_cmd;
  logic              cfg;
  logic [1:0]        supply_ff;
  logic [1:0]        clk_sel_ff;
  logic [1:0]        div_cnt_ff;
  logic              card_clk_ff;
  logic              sync_mode_ff;
  logic              drive_n_ff;
  logic              reset_ff;
  logic              sclk_bit_ff;
  logic              io_ff;
  logic              aux_a_ff;
  logic              aux_b_ff;
  logic              det_pol_ff;
  logic              special_ff;
  logic              fast_ff;
  logic              tick;

  // link side: the frame signal clears the bit count between frames
  // frame gated count
  always_ff @(posedge link.link_clk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_ff <= '0;
    end else if (!bit_cnt_ff[CNT_W-1]) begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!link.cs_n && !bit_cnt_ff[CNT_W-1]) begin
      shift_ff <= {shift_ff[BYTE_W-2:0], link.mosi};
    end
  end

  // readback launch; rb_ff only changes between frames, special_ff a few cycles after the eighth rising link edge
  // launch on rising
  always_ff @(posedge link.link_clk) begin
    rise_ff <= rb_ff[~bit_cnt_ff[2:0]];
  end

  always_ff @(negedge link.link_clk) begin
    fall_ff <= rb_ff[~bit_cnt_ff[2:0]];
  end

  assign link.miso = special_ff ? rise_ff
                   : ((bit_cnt_ff == '0) ? rb_ff[BYTE_W-1] : fall_ff);

  // crossings into clock_i
  always_ff @(posedge clock_i) begin
    done_sync_ff <= {done_sync_ff[1:0], bit_cnt_ff[CNT_W-1]};
    cs_sync_ff   <= {cs_sync_ff[0], link.cs_n};
    slot_s1_ff   <= {slot_address_pin_high_i, slot_address_pin_low_i};
    slot_s2_ff   <= slot_s1_ff;
    io_sync_ff   <= {io_sync_ff[0], card_data_line_i};
  end

  assign take = done_sync_ff[1] && !done_sync_ff[2];
  assign cmd  = shift_ff[CMD_MSB:CMD_LSB];
  assign dat  = shift_ff[DAT_MSB:0];
  assign prog = take && ((!cmd[2] && (cmd[1:0] == slot_s2_ff)) || (cmd == CMD_EXT_ASYNC));
  assign sync_cmd = take && (cmd == CMD_EXT_SYNC);
  assign cfg      = take && (cmd == CMD_CONFIG);

  // readback snapshot is frozen while a frame is open
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rb_ff <= '0;
    end else if (cs_sync_ff[1]) begin
      rb_ff <= {3'h0, det_pol_ff, io_sync_ff[1], aux_a_ff, aux_b_ff, supply_ff != VCC_OFF};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      supply_ff  <= VCC_OFF;
      clk_sel_ff <= CKS_LOW;
    end else if (prog) begin
      supply_ff  <= dat[VCC_MSB:VCC_LSB];
      clk_sel_ff <= dat[CLK_MSB:CLK_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reset_ff <= 1'b0;
    end else if (prog || sync_cmd) begin
      reset_ff <= dat[RST_BIT];
    end else if (cfg) begin
      reset_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_mode_ff <= 1'b0;
      drive_n_ff   <= 1'b1;
      sclk_bit_ff  <= 1'b0;
      io_ff        <= 1'b0;
      aux_a_ff     <= 1'b0;
      aux_b_ff     <= 1'b0;
    end else if (sync_cmd) begin
      sync_mode_ff <= 1'b1;
      drive_n_ff   <= 1'b0;
      sclk_bit_ff  <= dat[SYN_CLK];
      io_ff        <= dat[SYN_IO];
      aux_a_ff     <= dat[SYN_AUXA];
      aux_b_ff     <= dat[SYN_AUXB];
    end else if (prog) begin
      sync_mode_ff <= 1'b0;
      drive_n_ff   <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      det_pol_ff <= RST_DET_POL;
      special_ff <= RST_SPECIAL;
      fast_ff    <= RST_FAST;
    end else if (cfg) begin
      case (dat)
        CFG_DET_OPEN:   det_pol_ff <= 1'b0;
        CFG_DET_CLOSED: det_pol_ff <= 1'b1;
        CFG_EDGE_SPEC:  special_ff <= 1'b1;
        CFG_EDGE_NORM:  special_ff <= 1'b0;
        CFG_SLOPE_SLOW: fast_ff    <= 1'b0;
        CFG_SLOPE_FAST: fast_ff    <= 1'b1;
        default:        fast_ff    <= fast_ff;
      endcase
    end
  end

  // card clock: toggles at the selected rate of the time base, or follows sclk_bit_ff in sync mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  always_comb begin
    case (clk_sel_ff)
      CKS_DIV1: tick = 1'b1;
      CKS_DIV2: tick = div_cnt_ff[0];
      CKS_DIV4: tick = &div_cnt_ff;
      default:  tick = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      card_clk_ff <= 1'b0;
    end else if (sync_mode_ff) begin
      card_clk_ff <= sclk_bit_ff;
    end else if (clk_sel_ff == CKS_LOW) begin
      card_clk_ff <= 1'b0;
    end else if (tick) begin
      card_clk_ff <= ~card_clk_ff;
    end
  end

  assign card_supply_output_o      = supply_ff;
  assign card_clock_output_o       = card_clk_ff;
  assign card_clock_fast_slope_o   = fast_ff;
  assign card_reset_output_o       = reset_ff;
  assign card_data_line_o          = io_ff;
  assign card_data_line_oe_n_o     = drive_n_ff;
  assign card_aux_contact_a_o      = aux_a_ff;
  assign card_aux_contact_a_oe_n_o = drive_n_ff;
  assign card_aux_contact_b_o      = aux_b_ff;
  assign card_aux_contact_b_oe_n_o = drive_n_ff;
  assign card_detect_polarity_o    = det_pol_ff;
  assign serial_edge_special_o     = special_ff;
endmodule // ccd_coupler
`default_nettype wire

// ---- ccd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_host (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  ccd_link_if.host                    link,
  input  wire logic                   cmd_valid_i,
  input  wire logic [ccd_pkg::BYTE_W-1:0] cmd_byte_i,
  input  wire logic                   edge_special_i,
  output logic                        cmd_ready_o,
  output logic                        cmd_done_o,
  output logic [ccd_pkg::BYTE_W-1:0]  readback_o
);
  import ccd_pkg::*;

  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} ccd_hstate_t;

  localparam logic [TICK_W-1:0] HALF_LAST  = TICK_W'(HALF_CYC - 1);
  localparam logic [TICK_W-1:0] SETUP_LAST = TICK_W'(SETUP_CYC - 1);
  localparam logic [TICK_W-1:0] GAP_LAST   = TICK_W'(GAP_CYC - 1);

  ccd_hstate_t       state_ff;
  logic [TICK_W-1:0] tick_ff;
  logic [2:0]        bit_ff;
  logic [BYTE_W-1:0] tx_ff;
  logic [BYTE_W-1:0] rx_ff;
  logic [BYTE_W-1:0] readback_ff;
  logic [1:0]        miso_sync_ff;
  logic              special_ff;
  logic              sclk_ff;
  logic              cs_n_ff;
  logic              mosi_ff;
  logic              ready_ff;
  logic              done_ff;

  always_ff @(posedge clock_i) begin
    miso_sync_ff <= {miso_sync_ff[0], link.miso};
  end

  // one byte per frame; reserved code is the caller's duty
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff    <= HS_IDLE;
      tick_ff     <= '0;
      bit_ff      <= '0;
      tx_ff       <= '0;
      rx_ff       <= '0;
      readback_ff <= '0;
      special_ff  <= 1'b0;
      sclk_ff     <= 1'b0;
      cs_n_ff     <= 1'b1;
      mosi_ff     <= 1'b0;
      ready_ff    <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      tick_ff <= tick_ff + 1'b1;
      case (state_ff)
        HS_IDLE: begin
          ready_ff <= 1'b1;
          if (cmd_valid_i && ready_ff) begin
            ready_ff   <= 1'b0;
            tx_ff      <= cmd_byte_i;
            mosi_ff    <= cmd_byte_i[BYTE_W-1];
            special_ff <= edge_special_i;
            cs_n_ff    <= 1'b0;
            bit_ff     <= '0;
            tick_ff    <= '0;
            state_ff   <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (tick_ff == SETUP_LAST) begin
            tick_ff  <= '0;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick_ff == HALF_LAST) begin
            if (!special_ff) begin
              rx_ff <= {rx_ff[BYTE_W-2:0], miso_sync_ff[1]};
            end
            sclk_ff  <= 1'b1;
            tick_ff  <= '0;
            state_ff <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick_ff == HALF_LAST) begin
            if (special_ff) begin
              rx_ff <= {rx_ff[BYTE_W-2:0], miso_sync_ff[1]};
            end
            sclk_ff <= 1'b0;
            tick_ff <= '0;
            tx_ff   <= {tx_ff[BYTE_W-2:0], 1'b0};
            mosi_ff <= tx_ff[BYTE_W-2];
            bit_ff  <= bit_ff + 1'b1;
            state_ff <= (bit_ff == 3'h7) ? HS_TAIL : HS_LOW;
          end
        end
        HS_TAIL: begin
          if (tick_ff == HALF_LAST) begin
            cs_n_ff     <= 1'b1;
            readback_ff <= rx_ff;
            done_ff     <= 1'b1;
            tick_ff     <= '0;
            state_ff    <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick_ff == GAP_LAST) begin
            state_ff <= HS_IDLE;
          end
        end
        default: begin
          state_ff <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.link_clk = sclk_ff;
  assign link.cs_n     = cs_n_ff;
  assign link.mosi     = mosi_ff;
  assign cmd_ready_o   = ready_ff;
  assign cmd_done_o    = done_ff;
  assign readback_o    = readback_ff;
endmodule // ccd_host
`default_nettype wire

// ---- ccd_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_link_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic       clk_q_ff;
  logic [3:0] rise_cnt_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge clock_i) begin
    clk_q_ff <= link_clk;
  end

  // rising link edges seen in the current frame
  always_ff @(posedge clock_i) begin
    if (rst_i || cs_n) begin
      rise_cnt_ff <= 4'h0;
    end else if (link_clk && !clk_q_ff) begin
      rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end
  end

  idle_clock_a : assert property (
    cs_n |-> !link_clk) else $error("link clock not low outside frame");
  mosi_hold_a : assert property (
    link_clk |-> $stable(mosi)) else $error("mosi moved while link clock high");
  frame_length_a : assert property (
    $fell(cs_n) |-> ##72 $rose(cs_n)) else $error("frame length wrong");
  setup_time_a : assert property (
    $fell(cs_n) |-> (!link_clk) [*8] ##1 link_clk) else $error("first rise misplaced");
  high_half_a : assert property (
    $rose(link_clk) |-> link_clk [*4] ##1 !link_clk) else $error("high half wrong");
  low_half_a : assert property (
    $fell(link_clk) |-> (!link_clk) [*4]) else $error("low half too short");
  eight_bits_a : assert property (
    $rose(cs_n) |-> rise_cnt_ff == 4'h8) else $error("frame not eight bits");
  frame_gap_a : assert property (
    $rose(cs_n) |-> cs_n [*8]) else $error("gap between frames too short");
endmodule // ccd_link_sva
`default_nettype wire

// ---- card_coupler_command_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module card_coupler_command_decoder_tb;
  import ccd_pkg::*;
  logic       clock_i   = 1'b0;
  logic       rst_i     = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_byte  = 8'h00;
  logic       edge_sp   = 1'b0;
  logic       card_rel  = 1'b1;
  logic [1:0] strap     = 2'h2;
  logic       cmd_ready, cmd_done, cclk, cslope, crst, cdat, cdat_oe_n;
  logic       aux_a, aux_a_oe_n, aux_b, aux_b_oe_n, det, espec;
  logic [7:0] readback;
  logic [1:0] supply;
  wire logic  card_io;
  int         error_cnt    = 0;
  int         total_checks = 0;

  ccd_link_if link ();
  // card line pulled up when released by the coupler
  assign card_io = cdat_oe_n ? card_rel : cdat;

  ccd_host i_ccd_host (.clock_i(clock_i), .rst_i(rst_i), .link(link), .cmd_valid_i(cmd_valid),
    .cmd_byte_i(cmd_byte), .edge_special_i(edge_sp), .cmd_ready_o(cmd_ready),
    .cmd_done_o(cmd_done), .readback_o(readback));
  ccd_coupler i_ccd_coupler (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .slot_address_pin_low_i(strap[0]), .slot_address_pin_high_i(strap[1]),
    .card_data_line_i(card_io),
    .card_supply_output_o(supply), .card_clock_output_o(cclk), .card_clock_fast_slope_o(cslope),
    .card_reset_output_o(crst), .card_data_line_o(cdat), .card_data_line_oe_n_o(cdat_oe_n),
    .card_aux_contact_a_o(aux_a), .card_aux_contact_a_oe_n_o(aux_a_oe_n),
    .card_aux_contact_b_o(aux_b), .card_aux_contact_b_oe_n_o(aux_b_oe_n),
    .card_detect_polarity_o(det), .serial_edge_special_o(espec));
  ccd_link_sva i_ccd_link_sva (.clock_i(clock_i), .rst_i(rst_i), .link_clk(link.link_clk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one command frame through the host, waits for its completion
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge clock_i); #1; n++;
    end
    cmd_byte = b;
    cmd_valid = 1'b1;
    @(posedge clock_i); #1;
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 200) begin
      @(posedge clock_i); #1; n++;
    end
    `CHK("done", 1'b1, cmd_done)
  endtask

  task automatic t_reset();
    `CHK("supply", VCC_OFF, supply)
    `CHK("clock", 1'b0, cclk)
    `CHK("reset", 1'b0, crst)
    `CHK("oe_n", 1'b1, cdat_oe_n)
    `CHK("slope", RST_FAST, cslope)
    `CHK("detect", RST_DET_POL, det)
    `CHK("edge", RST_SPECIAL, espec)
    $display("test reset done");
  endtask

  task automatic t_prog();
    for (int v = 0; v < 4; v++) begin
      send({CMD_EXT_ASYNC, v[0], CKS_LOW, v[1:0]});
      `CHK("supply", v[1:0], supply)
      `CHK("reset", v[0], crst)
      `CHK("clock", 1'b0, cclk)
      `CHK("oe_n", 1'b1, cdat_oe_n)
      `CHK("aux a oe_n", 1'b1, aux_a_oe_n)
      `CHK("aux b oe_n", 1'b1, aux_b_oe_n)
    end
    $display("test program done");
  endtask

  task automatic t_clkdiv();
    int   r;
    logic p;
    for (int k = 1; k < 4; k++) begin
      send({CMD_EXT_ASYNC, 1'b0, k[1:0], 2'h1});
      r = 0;
      p = cclk;
      repeat (64) begin
        @(posedge clock_i); #1;
        if (cclk && !p) r++;
        p = cclk;
      end
      `CHK("clock rises", 32 >> (k - 1), r)
    end
    $display("test divider done");
  endtask

  task automatic t_slot();
    send({3'h1, 5'h03});
    `CHK("supply", 2'h1, supply)
    strap = 2'h1;
    send({3'h1, 5'h02});
    `CHK("supply", 2'h2, supply)
    send({3'h2, 5'h03});
    `CHK("supply", 2'h2, supply)
    strap = 2'h2;
    send({3'h2, 5'h03});
    `CHK("supply", 2'h3, supply)
    $display("test slot done");
  endtask

  task automatic t_sync();
    logic [4:0] d [2] = '{5'h1D, 5'h02};
    foreach (d[i]) begin
      send({CMD_EXT_SYNC, d[i]});
      `CHK("reset", d[i][4], crst)
      `CHK("clock", d[i][3], cclk)
      `CHK("data", d[i][2], cdat)
      `CHK("aux a", d[i][1], aux_a)
      `CHK("aux b", d[i][0], aux_b)
      `CHK("oe_n", 1'b0, aux_b_oe_n)
      `CHK("data oe_n", 1'b0, cdat_oe_n)
      `CHK("aux a oe_n", 1'b0, aux_a_oe_n)
      `CHK("supply", 2'h3, supply)
    end
    $display("test sync done");
  endtask

  task automatic t_rb(input logic [7:0] exp);
    // unmatched slot code: reads back without touching this coupler
    send({3'h0, 5'h1F});
    `CHK("readback", exp, readback)
    `CHK("reset", 1'b0, crst)
    `CHK("supply", 2'h3, supply)
    $display("test readback done");
  endtask

  task automatic t_cfg();
    logic [4:0] c [6] = '{5'h00, 5'h04, 5'h03, 5'h01, 5'h02, 5'h05};
    send({CMD_EXT_SYNC, 5'h12});
    foreach (c[i]) begin
      `CHK("reset before", c[i] == 5'h00, crst)
      // data bit 4 kept low for configuration
      send({CMD_CONFIG, c[i]});
      `CHK("reset", 1'b0, crst)
      if (c[i] < 5'h02) `CHK("detect", c[i][0], det)
      else if (c[i] < 5'h04) `CHK("edge", ~c[i][0], espec)
      else `CHK("slope", c[i][0], cslope)
      if (c[i] == 5'h02) edge_sp = 1'b1;
      if (c[i] == 5'h03) edge_sp = 1'b0;
    end
    $display("test config done");
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    #1 rst_i = 1'b0;
    @(posedge clock_i); #1;
    t_reset();
    t_prog();
    t_clkdiv();
    t_slot();
    t_sync();
    t_rb(8'h05);
    t_cfg();
    t_rb(8'h15);
    finish_test();
  end

  initial begin
    #1000000;
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end
endmodule // card_coupler_command_decoder_tb
`undef CHK
`default_nettype wire
